// ===== adc_device.sv
// Purpose: converter end: sampling, conversion timing and result readout
// Assumes: link pins are synchronous to i_sys_clk
// Notes: analog inputs arrive as already-quantised 12-bit codes
`default_nettype none
module adc_device #(
   parameter int CONV_HS = adc_pkg::CONV_HS_CYC,
   parameter int CONV_AS = adc_pkg::CONV_AS_CYC,
   parameter bit BIPOLAR = 1'b1
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Mode strap and analog codes
   input wire logic i_auto_sleep,
   input wire logic [adc_pkg::DATA_W-1:0] i_chan_a_input_1,
   input wire logic [adc_pkg::DATA_W-1:0] i_chan_a_input_2,
   input wire logic [adc_pkg::DATA_W-1:0] i_chan_b_input_1,
   input wire logic [adc_pkg::DATA_W-1:0] i_chan_b_input_2,
   // Status
   output logic o_asleep,
   // Link
   adc_link_if.device link
);
   import adc_pkg::*;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_CONV = 2'b10
   } dev_state_e;

   typedef struct packed {
      dev_state_e st;
      logic [CNT_W-1:0] cnt;
      logic cs_prev;
      logic rd_prev;
      logic conv_prev;
      logic [DATA_W-1:0] held1;
      logic [DATA_W-1:0] held2;
      logic [DATA_W-1:0] res1;
      logic [DATA_W-1:0] res2;
      logic second;
      logic busy;
      logic asleep;
      logic [DATA_W-1:0] dout;
      logic oe;
   } dev_s;

   dev_s cur_ff;
   dev_s nxt_cur;

   // Code flip for unipolar variant keeps msb at bit 11 either way
   function automatic logic [DATA_W-1:0] code(
      input logic [DATA_W-1:0] v);
      code = BIPOLAR ? v : (v ^ 12'h800);
   endfunction : code

   // Sequencer and readout
   always_comb begin
      logic fall;
      logic rd_end;
      fall = 1'b0;
      rd_end = 1'b0;
      nxt_cur = cur_ff;
      fall = cur_ff.conv_prev & ~link.convert_start_n;
      rd_end = ~(cur_ff.cs_prev | cur_ff.rd_prev) &
         (link.cs_n | link.rd_n);
      nxt_cur.conv_prev = link.convert_start_n;
      nxt_cur.cs_prev = link.cs_n;
      nxt_cur.rd_prev = link.rd_n;
      unique case (cur_ff.st)
         S_IDLE: begin
            if (fall) begin
               // Both pair members frozen on the same edge
               nxt_cur.held1 = link.channel_select ?
                  i_chan_b_input_1 : i_chan_a_input_1;
               nxt_cur.held2 = link.channel_select ?
                  i_chan_b_input_2 : i_chan_a_input_2;
               nxt_cur.busy = 1'b1;
               nxt_cur.asleep = 1'b0;
               nxt_cur.second = 1'b0;
               nxt_cur.cnt = '0;
               nxt_cur.st = S_CONV;
            end
         end
         S_CONV: begin
            nxt_cur.cnt = cur_ff.cnt + 1'b1;
            // Sleep mode adds wake-up time to the conversion
            if (32'(cur_ff.cnt) + 1 >=
                  (i_auto_sleep ? CONV_AS : CONV_HS)) begin
               nxt_cur.res1 = code(cur_ff.held1);
               nxt_cur.res2 = code(cur_ff.held2);
               nxt_cur.busy = 1'b0;
               nxt_cur.asleep = i_auto_sleep;
               nxt_cur.st = S_IDLE;
            end
         end
         default: nxt_cur.st = S_IDLE;
      endcase
      // Reads during conversion return stale data, host must avoid
      nxt_cur.oe = ~link.cs_n & ~link.rd_n;
      nxt_cur.dout = cur_ff.second ? cur_ff.res2 : cur_ff.res1;
      if (rd_end && cur_ff.st == S_IDLE) begin
         nxt_cur.second = ~cur_ff.second;
      end
      if (fall) begin
         nxt_cur.second = 1'b0;
      end
   end

   // State register
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         cur_ff <= '{st: S_IDLE, cnt: '0, cs_prev: 1'b1, rd_prev: 1'b1,
            conv_prev: 1'b1, held1: RESULT_RST, held2: RESULT_RST,
            res1: RESULT_RST, res2: RESULT_RST, second: 1'b0,
            busy: 1'b0, asleep: 1'b0, dout: RESULT_RST, oe: 1'b0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign link.busy = cur_ff.busy;
   assign link.result_bus_o = cur_ff.dout;
   assign link.result_bus_oe = cur_ff.oe;
   assign o_asleep = cur_ff.asleep;
endmodule : adc_device
`default_nettype wire

// ===== adc_host.sv
// Purpose: host end: starts conversions and reads both results
// Assumes: link pins are synchronous to i_sys_clk
// Notes: two-entry buffer holds results until the user takes them
`default_nettype none
module adc_host #(
   parameter int ACQ = adc_pkg::ACQ_CYC,
   parameter int PERIOD = adc_pkg::PERIOD_CYC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Request
   input wire logic i_start,
   input wire logic i_channel,
   output logic o_ready,
   // Result stream
   output logic o_valid,
   output logic [adc_pkg::DATA_W-1:0] o_data,
   input wire logic i_take,
   // Link
   adc_link_if.host link
);
   import adc_pkg::*;

   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_CONV = 5'b00010,
      H_WAIT = 5'b00100,
      H_RDLO = 5'b01000,
      H_RDHI = 5'b10000
   } host_state_e;

   typedef struct packed {
      host_state_e st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] gap;
      logic nread;
      logic conv_n;
      logic sel;
      logic cs_n;
      logic rd_n;
      logic [1:0][DATA_W-1:0] buf_d;
      logic [1:0] cnt_b;
      logic wp;
      logic rp;
   } host_s;

   host_s cur_ff;
   host_s nxt_cur;

   // Read sequencing and two-entry buffer
   always_comb begin
      logic push;
      logic pop;
      push = 1'b0;
      pop = 1'b0;
      nxt_cur = cur_ff;
      nxt_cur.cnt = cur_ff.cnt + 1'b1;
      if (cur_ff.gap != '0) nxt_cur.gap = cur_ff.gap - 1'b1;
      unique case (cur_ff.st)
         H_IDLE: begin
            nxt_cur.conv_n = 1'b1;
            // Acquisition and period spacing kept by gap
            if (i_start && cur_ff.gap == '0 && cur_ff.cnt_b == 2'd0) begin
               nxt_cur.sel = i_channel;
               nxt_cur.conv_n = 1'b0;
               nxt_cur.gap = CNT_W'(PERIOD);
               nxt_cur.cnt = '0;
               nxt_cur.st = H_CONV;
            end
         end
         H_CONV: begin
            if (cur_ff.cnt == 12'h001) nxt_cur.conv_n = 1'b1;
            // No reads until busy is low again
            if (cur_ff.cnt > 12'h002 && !link.busy) begin
               nxt_cur.nread = 1'b0;
               nxt_cur.st = H_RDLO;
            end
         end
         H_RDLO: begin
            nxt_cur.cs_n = 1'b0;
            nxt_cur.rd_n = 1'b0;
            nxt_cur.cnt = '0;
            nxt_cur.st = H_WAIT;
         end
         H_WAIT: begin
            if (cur_ff.cnt == CNT_W'(RD_LOW_CYC - 1)) begin
               push = 1'b1;
               nxt_cur.cs_n = 1'b1;
               nxt_cur.rd_n = 1'b1;
               nxt_cur.cnt = '0;
               nxt_cur.st = H_RDHI;
            end
         end
         H_RDHI: begin
            if (cur_ff.cnt == CNT_W'(RD_HIGH_CYC - 1)) begin
               nxt_cur.nread = 1'b1;
               nxt_cur.st = cur_ff.nread ? H_IDLE : H_RDLO;
               // Keep whichever spacing ends later, period or acquisition
               if (cur_ff.nread && cur_ff.gap < CNT_W'(ACQ)) begin
                  nxt_cur.gap = CNT_W'(ACQ);
               end
            end
         end
         default: nxt_cur.st = H_IDLE;
      endcase
      pop = i_take && cur_ff.cnt_b != 2'd0;
      if (push) begin
         nxt_cur.buf_d[cur_ff.wp] = link.result_bus;
         nxt_cur.wp = ~cur_ff.wp;
      end
      if (pop) nxt_cur.rp = ~cur_ff.rp;
      nxt_cur.cnt_b = cur_ff.cnt_b + {1'b0, push} - {1'b0, pop};
   end

   // State register
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         cur_ff <= '{st: H_IDLE, cnt: '0, gap: '0, nread: 1'b0,
            conv_n: 1'b1, sel: 1'b0, cs_n: 1'b1, rd_n: 1'b1,
            buf_d: '0, cnt_b: 2'd0, wp: 1'b0, rp: 1'b0};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs straight from the state register
   assign link.convert_start_n = cur_ff.conv_n;
   assign link.channel_select = cur_ff.sel;
   assign link.cs_n = cur_ff.cs_n;
   assign link.rd_n = cur_ff.rd_n;
   assign o_ready = cur_ff.st == H_IDLE && cur_ff.gap == '0
      && cur_ff.cnt_b == 2'd0;
   assign o_valid = cur_ff.cnt_b != 2'd0;
   assign o_data = cur_ff.buf_d[cur_ff.rp];
endmodule : adc_host
`default_nettype wire

// ===== adc_link_checker.sv
// Purpose: timing checks on the pins between host and converter
// Assumes: one clock, synchronous active-high reset
// Notes: bounds follow the shortened counts set by the bench
`default_nettype none
module adc_link_checker #(
   parameter int CONV_AS = 30
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // Link pins
   input wire logic convert_start_n,
   input wire logic channel_select,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic busy,
   input wire logic [11:0] result_bus_o,
   input wire logic result_bus_oe
);
   // Slack of a few cycles for edge detect and flag registers
   localparam int BUSY_MAX = CONV_AS + 4;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);
   a_start_pulse: assert property ($fell(convert_start_n) |=>
      !convert_start_n ##1 convert_start_n) else $error("bad start pulse");
   a_busy_on_start: assert property ($fell(convert_start_n)
      |-> ##[1:2] busy) else $error("busy did not rise");
   a_conv_time: assert property ($rose(busy) |-> busy[*8]
      ##[1:BUSY_MAX] !busy) else $error("conversion length wrong");
   a_chan_held: assert property ($past(busy) && busy
      |-> $stable(channel_select)) else $error("channel moved");
   a_quiet_busy: assert property (busy |-> rd_n && !result_bus_oe)
      else $error("read during conversion");
   a_reads_follow: assert property ($fell(busy)
      |-> ##[1:20] $fell(rd_n)) else $error("no read after busy");
   a_acq_gap: assert property ($fell(busy)
      |-> convert_start_n[*8]) else $error("start too soon");
   a_rd_with_cs: assert property (!rd_n |-> !cs_n)
      else $error("read strobe without select");
   a_oe_strobes: assert property (result_bus_oe
      |-> (!cs_n && !rd_n) || $past(!cs_n && !rd_n))
      else $error("bus driven outside a read");
   a_data_steady: assert property (result_bus_oe
      && $past(result_bus_oe) |-> $stable(result_bus_o))
      else $error("bus data moved in a read");
endmodule : adc_link_checker
`default_nettype wire

// ===== adc_link_if.sv
// Purpose: pins between the host controller and the converter
// Assumes: one system clock shared by both ends
// Notes: result bus resolved here from the converter's enable
`default_nettype none
interface adc_link_if;
   logic convert_start_n;
   logic channel_select;
   logic cs_n;
   logic rd_n;
   logic busy;
   logic [11:0] result_bus_o;
   logic result_bus_oe;
   logic [11:0] result_bus;
   // Undriven bus reads as zero
   assign result_bus = result_bus_oe ? result_bus_o : 12'h000;
   modport device (input convert_start_n, input channel_select,
      input cs_n, input rd_n, output busy, output result_bus_o,
      output result_bus_oe);
   modport host (output convert_start_n, output channel_select,
      output cs_n, output rd_n, input busy, input result_bus);
endinterface : adc_link_if
`default_nettype wire

// ===== adc_pkg.sv
// Purpose: shared constants for the dual sampling converter link
// Assumes: 250 MHz system clock on both ends
// Notes: times are kept in ns, counts derived from the clock period
`default_nettype none
package adc_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int DATA_W = 12;
   // Conversion times per mode, then acquisition, read guard and throughput times
   localparam int CONV_HS_NS = 3600;
   localparam int CONV_AS_NS = 6000;
   localparam int ACQ_NS = 300;
   localparam int READ_GUARD_NS = 300;
   localparam int THROUGHPUT_NS = 4000;
   // Longest times round down, least times round up
   localparam int CONV_HS_CYC = CONV_HS_NS / CLK_PERIOD_NS;
   localparam int CONV_AS_CYC = CONV_AS_NS / CLK_PERIOD_NS;
   localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GUARD_CYC =
      (READ_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PERIOD_CYC = THROUGHPUT_NS / CLK_PERIOD_NS;
   localparam int CNT_W = 12;
   // Read strobe low and high widths on the host side
   localparam int RD_LOW_CYC = 2;
   localparam int RD_HIGH_CYC = 2;
   localparam int CS_LOW_CYC = 2;
   localparam logic [11:0] RESULT_RST = 12'h000;
   localparam logic MODE_HIGH_SAMPLE = 1'b0;
   localparam logic MODE_AUTO_SLEEP = 1'b1;
endpackage : adc_pkg
`default_nettype wire

// ===== tb_dual_sim_sample_adc_ctrl.sv
// Purpose: host and converter ends run against each other
// Assumes: shortened conversion counts, acquisition gap of 4
// Notes: codes change once busy rises, so a late sample shows
`default_nettype none
module tb_dual_sim_sample_adc_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_pkg::*;
   localparam int HS = 20;
   localparam int AS = 30;
   logic sys_clk, sys_rst, auto_sleep, asleep;
   logic start, channel, ready, valid, take;
   logic [DATA_W-1:0] data;
   logic [DATA_W-1:0] code [4];
   int n_errors = 0;
   int tests_run = 0;
   int seed = 32'h3fef883a;
   adc_link_if link ();
   adc_device #(.CONV_HS(HS), .CONV_AS(AS), .BIPOLAR(1'b1)) adc_device_i (
      .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_auto_sleep(auto_sleep),
      .i_chan_a_input_1(code[0]), .i_chan_a_input_2(code[1]),
      .i_chan_b_input_1(code[2]), .i_chan_b_input_2(code[3]),
      .o_asleep(asleep), .link(link));
   adc_host #(.ACQ(4), .PERIOD(40)) adc_host_i (
      .i_sys_clk(sys_clk), .i_sys_rst(sys_rst), .i_start(start),
      .i_channel(channel), .o_ready(ready), .o_valid(valid),
      .o_data(data), .i_take(take), .link(link));
   adc_link_checker #(.CONV_AS(AS)) adc_link_checker_i (
      .i_sys_clk(sys_clk), .i_sys_rst(sys_rst),
      .convert_start_n(link.convert_start_n),
      .channel_select(link.channel_select), .cs_n(link.cs_n),
      .rd_n(link.rd_n), .busy(link.busy),
      .result_bus_o(link.result_bus_o),
      .result_bus_oe(link.result_bus_oe));
   // Clock of 4 ns
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic wrap_up();
      $display("Checks %0d, errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic timeout();
      chk(12'h000, 12'h001);
      wrap_up();
   endtask : timeout
   // Bipolar variant passes the code through unchanged
   function automatic logic [11:0] exp_word(input logic [11:0] c [4],
         input logic ch, input logic sec);
      return c[{ch, sec}];
   endfunction : exp_word
   // At least one edge first, so a pop just made has landed
   task automatic get(input logic [11:0] exp);
      int n;
      n = 0;
      repeat (1 + ($random(seed) & 7)) @(posedge sys_clk);
      while (valid !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 300) timeout();
      chk(data, exp);
      take <= 1'b1;
      @(posedge sys_clk);
      take <= 1'b0;
   endtask : get
   task automatic run(input logic ch, input logic md);
      logic [11:0] held [4];
      int n;
      channel <= ch;
      auto_sleep <= md;
      start <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ready !== 1'b1 && n < 200);
      if (n >= 200) timeout();
      start <= 1'b0;
      held = code;
      n = 0;
      while (link.busy !== 1'b1 && n < 10) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 10) timeout();
      for (int i = 0; i < 4; i++) code[i] <= 12'($random(seed));
      n = 0;
      while (link.busy === 1'b1 && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      chk({11'h0, n <= (md ? AS : HS) + 2}, 12'h001);
      repeat (2) @(posedge sys_clk);
      chk({11'h0, asleep}, {11'h0, md});
      get(exp_word(held, ch, 1'b0));
      get(exp_word(held, ch, 1'b1));
   endtask : run
   // Bound on the whole run
   initial begin
      repeat (100000) @(posedge sys_clk);
      timeout();
   end
   // Extreme codes first, then every channel and mode pairing
   initial begin
      sys_rst = 1'b1;
      start = 1'b0;
      channel = 1'b0;
      take = 1'b0;
      auto_sleep = 1'b0;
      code = '{12'h000, 12'hfff, 12'h800, 12'h7ff};
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int k = 0; k < 12; k++) run(k[0], k[1]);
      wrap_up();
   end
endmodule : tb_dual_sim_sample_adc_ctrl
`default_nettype wire
